// >>> inc/flash_seq_defs.svh
// offsets, command codes, reset values and timing counts of the flash sequencer
`ifndef FLASH_SEQ_DEFS_SVH
`define FLASH_SEQ_DEFS_SVH

// bus map: haddr bit 14 low selects the flash array, high the sequencer status word
`define FLASH_REGION_BIT 14
`define STATUS_REG_OFFSET 32'h0000_4000

// unlock addresses, as flash byte index = haddr[13:2]
`define UNLOCK_ADDR_A 12'h555
`define UNLOCK_ADDR_B 12'hAAA

// command bytes
`define CMD_UNLOCK_1 8'hAA
`define CMD_UNLOCK_2 8'h55
`define CMD_ERASE_SETUP 8'h80
`define CMD_PROGRAM 8'hA0
`define CMD_BULK_ERASE 8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_ERASE_RESUME 8'h30
`define CMD_ERASE_SUSPEND 8'hB0
`define CMD_RESET 8'hF0

// array values
`define ERASED_BYTE 8'hFF
`define PREPROG_BYTE 8'h00
`define SUSPENDED_JUNK 8'h5A
`define ARRAY_RESET_BYTE 8'hFF

// status byte bit positions
`define POLL_BIT 7
`define TOGGLE_BIT 6
`define ERROR_BIT 5
`define WINDOW_BIT 3

// timing: clock period and documented times in ns
`define CLK_PERIOD_NS 50
`define WINDOW_TIME_NS 100000
`define SUSPEND_MIN_NS 100
`define WINDOW_CYC (`WINDOW_TIME_NS / `CLK_PERIOD_NS)
`define SUSPEND_CYC ((`SUSPEND_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_CYC 8
`define MAX_ERASE_TRIES 3

`endif

// >>> inc/flash_seq_pkg.sv
// types shared by the flash sequencer and its erase walker
package flash_seq_pkg;

  typedef enum logic [3:0] {
    ST_READ      = 4'b0000,
    ST_PROG      = 4'b0001,
    ST_BULK      = 4'b0010,
    ST_WINDOW    = 4'b0011,
    ST_SECT      = 4'b0100,
    ST_SUSP_PEND = 4'b0101,
    ST_SUSPENDED = 4'b0110,
    ST_ERROR     = 4'b0111
  } seq_state_t;

  typedef enum logic [1:0] {
    WK_IDLE   = 2'b00,
    WK_PRE    = 2'b01,
    WK_ERASE  = 2'b10,
    WK_VERIFY = 2'b11
  } walk_phase_t;

  typedef struct packed {
    logic        write;
    logic        flash_sel;
    logic [11:0] idx;
  } bus_req_t;

  typedef struct packed {
    logic       poll;
    logic       toggle;
    logic       error;
    logic       rsvd4;
    logic       window;
    logic [2:0] rsvd;
  } status_byte_t;

endpackage

// >>> rtl/erase_walker.sv
// erase engine: preprograms then erases selected sectors, with verify and retries
`timescale 1ns/10ps
`include "flash_seq_defs.svh"
module erase_walker (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic       hold_i,
  input  wire logic [7:0] sectors_i,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       fault_i,
  output logic      [6:0] addr_o,
  output logic            wr_en_o,
  output logic      [7:0] wr_data_o,
  output logic            done_o,
  output logic            fail_o
);

  flash_seq_pkg::walk_phase_t phase_q;
  logic [1:0] tries_q;
  logic       bad_q;
  logic       sel_hit;
  logic       last;

  assign sel_hit   = sectors_i[addr_o[6:4]];
  assign last      = (addr_o == 7'h7F);
  assign wr_en_o   = !hold_i && sel_hit &&
                     (phase_q == flash_seq_pkg::WK_PRE || phase_q == flash_seq_pkg::WK_ERASE);
  assign wr_data_o = (phase_q == flash_seq_pkg::WK_PRE) ? `PREPROG_BYTE : `ERASED_BYTE;

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || abort_i) begin
      phase_q <= flash_seq_pkg::WK_IDLE;
      addr_o  <= 7'h00;
      tries_q <= 2'h0;
      bad_q   <= 1'b0;
      done_o  <= 1'b0;
      fail_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        phase_q <= flash_seq_pkg::WK_PRE;
        addr_o  <= 7'h00;
        tries_q <= 2'h0;
        bad_q   <= 1'b0;
        fail_o  <= 1'b0;
      end else if (!hold_i && phase_q != flash_seq_pkg::WK_IDLE) begin
        addr_o <= addr_o + 7'h01;
        unique case (phase_q)
          flash_seq_pkg::WK_PRE: begin
            if (last) phase_q <= flash_seq_pkg::WK_ERASE;
          end
          flash_seq_pkg::WK_ERASE: begin
            if (last) begin
              phase_q <= flash_seq_pkg::WK_VERIFY;
              bad_q   <= 1'b0;
            end
          end
          flash_seq_pkg::WK_VERIFY: begin
            // a weak cell keeps the pass failing until the retry budget runs out
            if (sel_hit && (fault_i || rd_data_i != `ERASED_BYTE)) bad_q <= 1'b1;
            if (last) begin
              if (bad_q || (sel_hit && (fault_i || rd_data_i != `ERASED_BYTE))) begin
                if (tries_q == 2'(`MAX_ERASE_TRIES - 1)) begin
                  phase_q <= flash_seq_pkg::WK_IDLE;
                  done_o  <= 1'b1;
                  fail_o  <= 1'b1;
                end else begin
                  tries_q <= tries_q + 2'h1;
                  phase_q <= flash_seq_pkg::WK_ERASE;
                end
              end else begin
                phase_q <= flash_seq_pkg::WK_IDLE;
                done_o  <= 1'b1;
              end
            end
          end
          flash_seq_pkg::WK_IDLE: begin
            phase_q <= flash_seq_pkg::WK_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// >>> rtl/flash_erase_status_sequencer.sv
// flash command sequencer with toggle/error status, bulk and sector erase, suspend/resume
//
// Overview of operation
// - Toggle status bit inverts on each host status read while programming runs.
// - Error sets on program timer expiry or programming a one over a zero.
// - Toggle inverts until erase ends; erasing-sector reads return status bits.
// - After erase, error one means timeout failure, zero means success.
// - Bulk erase is six host writes followed by a status read.
// - Any mismatching byte abandons the command and returns to array read.
// - Bulk erase error reads one when all internal erase tries failed.
// - Device preprograms affected bytes to 00h then erases them to 0FFh.
// - All commands are ignored while bulk erase executes.
// - Sector confirm writes within about 100 us add sectors and restart window.
// - Erase window bit reads zero while window counts, one once erasing.
// - Before or in window, non-suspend/resume commands abort to array read.
// - During sector erase execution only reset and suspend are accepted.
// - Suspend is 0B0h to any flash address, honoured only in sector erase.
// - Suspend during the window suspends erase and ends the window.
// - Toggle stops 0.1 to 15 us after suspend, then array read mode.
// - Suspended: erasing-sector reads give undefined data, others array contents.
// - Suspended: no programming; only resume and reset accepted; reads still served.
// - Reset while suspended leaves the erasing sector's contents undefined.
// - Resume is 030h to any flash address and continues the suspended erase.
`timescale 1ns/10ps
`include "flash_seq_defs.svh"
module flash_erase_status_sequencer (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  input  wire logic        wear_fault_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             busy_o
);

  flash_seq_pkg::seq_state_t   state_q;
  flash_seq_pkg::bus_req_t     req_q;
  flash_seq_pkg::status_byte_t status;

  logic [7:0]  mem_q [0:127];
  logic        pend_q;
  logic [2:0]  step_q;
  logic        prog_arm_q;
  logic [6:0]  prog_addr_q;
  logic [7:0]  prog_data_q;
  logic [3:0]  prog_cnt_q;
  logic [10:0] win_cnt_q;
  logic [1:0]  susp_cnt_q;
  logic [7:0]  sectors_q;
  logic        toggle_q;
  logic        walk_started_q;
  logic        walk_start_q;
  logic        walk_abort_q;

  logic        wr_cmd;
  logic        rd_acc;
  logic [7:0]  wbyte;
  logic [6:0]  aidx;
  logic        in_erase_sect;
  logic        status_read;
  logic [7:0]  mem_rd;
  logic [6:0]  walk_addr;
  logic        walk_wr;
  logic [7:0]  walk_data;
  logic        walk_done;
  logic        walk_fail;
  logic        walk_hold;
  logic        erasing;
  logic        cap;
  logic        prog_commit;

  // the data phase always takes one wait state so that hrdata comes from a flop
  assign cap     = hsel_i && hready_i && htrans_i[1] && !pend_q;
  // decoded view of the pending data phase
  assign wr_cmd  = pend_q && req_q.write && req_q.flash_sel;
  assign rd_acc  = pend_q && !req_q.write && req_q.flash_sel;
  assign wbyte   = hwdata_i[7:0];
  assign aidx    = req_q.idx[6:0];
  assign mem_rd  = mem_q[aidx];
  assign prog_commit = (state_q == flash_seq_pkg::ST_PROG) && (prog_cnt_q == 4'h1) &&
                       !wear_fault_i;

  assign erasing = (state_q == flash_seq_pkg::ST_WINDOW) ||
                   (state_q == flash_seq_pkg::ST_SECT) ||
                   (state_q == flash_seq_pkg::ST_SUSP_PEND) ||
                   (state_q == flash_seq_pkg::ST_BULK);
  assign in_erase_sect = sectors_q[aidx[6:4]];
  assign walk_hold = (state_q == flash_seq_pkg::ST_SUSP_PEND) ||
                     (state_q == flash_seq_pkg::ST_SUSPENDED) ||
                     (state_q == flash_seq_pkg::ST_WINDOW);

  // reads that return the status byte instead of array data
  assign status_read = rd_acc && ((state_q == flash_seq_pkg::ST_PROG) ||
                       (state_q == flash_seq_pkg::ST_BULK) ||
                       (state_q == flash_seq_pkg::ST_ERROR) ||
                       (erasing && in_erase_sect));

  always_comb begin
    status        = '0;
    status.toggle = toggle_q;
    status.error  = (state_q == flash_seq_pkg::ST_ERROR);
    status.window = erasing && (state_q != flash_seq_pkg::ST_WINDOW);
    status.poll   = (state_q == flash_seq_pkg::ST_PROG) ? ~prog_data_q[7] : 1'b0;
  end

  // the walker verifies each cell straight from the array it has just written
  erase_walker u_walker (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (walk_start_q),
    .abort_i   (walk_abort_q),
    .hold_i    (walk_hold),
    .sectors_i (sectors_q),
    .rd_data_i (mem_q[walk_addr]),
    .fault_i   (wear_fault_i),
    .addr_o    (walk_addr),
    .wr_en_o   (walk_wr),
    .wr_data_o (walk_data),
    .done_o    (walk_done),
    .fail_o    (walk_fail)
  );

  // bus slave handshake: capture address phase, answer after one wait state
  // hsize is not looked at: every transfer is taken as a whole word
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pend_q      <= 1'b0;
      req_q       <= '0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      if (cap) begin
        pend_q          <= 1'b1;
        req_q.write     <= hwrite_i;
        req_q.flash_sel <= !haddr_i[`FLASH_REGION_BIT];
        req_q.idx       <= haddr_i[13:2];
        hreadyout_o     <= 1'b0;
      end else if (pend_q) begin
        pend_q      <= 1'b0;
        hreadyout_o <= 1'b1;
      end
    end
  end

  // read data register; status word sits outside the flash region
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (pend_q && !req_q.write) begin
      if (!req_q.flash_sel) begin
        hrdata_o <= {16'h0000, sectors_q, 3'b000, busy_o, state_q};
      end else if (status_read) begin
        hrdata_o <= {24'h00_0000, status};
      end else if (state_q == flash_seq_pkg::ST_SUSPENDED && in_erase_sect) begin
        // a half-erased cell is never shown; software must not trust this value
        hrdata_o <= {24'h00_0000, `SUSPENDED_JUNK};
      end else begin
        hrdata_o <= {24'h00_0000, mem_rd};
      end
    end
  end

  // toggle bit inverts once per status read while an algorithm runs or has failed
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      toggle_q <= 1'b0;
    end else if (status_read && state_q != flash_seq_pkg::ST_READ) begin
      toggle_q <= ~toggle_q;
    end
  end

  // array storage; the walker and the program commit never overlap in time
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < 128; i++) begin
        mem_q[i] <= `ARRAY_RESET_BYTE;
      end
    end else if (walk_wr) begin
      mem_q[walk_addr] <= walk_data;
    end else if (prog_commit) begin
      // program can only clear bits; the and keeps zeros that are already there
      mem_q[prog_addr_q] <= mem_q[prog_addr_q] & prog_data_q;
    end
  end

  // unlock sequence step counter, shared by program and both erase commands
  // a stray byte or a reset byte anywhere in the sequence drops back to step zero
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      step_q     <= 3'd0;
      prog_arm_q <= 1'b0;
    end else if (wr_cmd && state_q == flash_seq_pkg::ST_READ) begin
      step_q     <= 3'd0;
      prog_arm_q <= 1'b0;
      if (!prog_arm_q && wbyte != `CMD_RESET) begin
        unique case (step_q)
          3'd0: if (wbyte == `CMD_UNLOCK_1 && req_q.idx == `UNLOCK_ADDR_A) step_q <= 3'd1;
          3'd1: if (wbyte == `CMD_UNLOCK_2 && req_q.idx == `UNLOCK_ADDR_B) step_q <= 3'd2;
          3'd2: begin
            if (req_q.idx == `UNLOCK_ADDR_A && wbyte == `CMD_ERASE_SETUP) step_q <= 3'd3;
            if (req_q.idx == `UNLOCK_ADDR_A && wbyte == `CMD_PROGRAM) prog_arm_q <= 1'b1;
          end
          3'd3: if (wbyte == `CMD_UNLOCK_1 && req_q.idx == `UNLOCK_ADDR_A) step_q <= 3'd4;
          3'd4: if (wbyte == `CMD_UNLOCK_2 && req_q.idx == `UNLOCK_ADDR_B) step_q <= 3'd5;
          default: step_q <= 3'd0;
        endcase
      end
    end
  end

  // main sequencer
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_q        <= flash_seq_pkg::ST_READ;
      sectors_q      <= 8'h00;
      prog_addr_q    <= 7'h00;
      prog_data_q    <= 8'h00;
      prog_cnt_q     <= 4'h0;
      win_cnt_q      <= 11'h000;
      susp_cnt_q     <= 2'h0;
      walk_started_q <= 1'b0;
      walk_start_q   <= 1'b0;
      walk_abort_q   <= 1'b0;
      busy_o         <= 1'b0;
    end else begin
      walk_start_q <= 1'b0;
      walk_abort_q <= 1'b0;
      unique case (state_q)
        flash_seq_pkg::ST_READ: begin
          if (wr_cmd && prog_arm_q) begin
            prog_addr_q <= aidx;
            prog_data_q <= wbyte;
            // zeros can only be raised by an erase, so a one over a zero fails at once
            if ((wbyte & ~mem_rd) != 8'h00) begin
              state_q <= flash_seq_pkg::ST_ERROR;
            end else begin
              state_q    <= flash_seq_pkg::ST_PROG;
              prog_cnt_q <= 4'(`PROG_CYC);
            end
          end else if (wr_cmd && step_q == 3'd5) begin
            if (wbyte == `CMD_BULK_ERASE && req_q.idx == `UNLOCK_ADDR_A) begin
              state_q        <= flash_seq_pkg::ST_BULK;
              sectors_q      <= 8'hFF;
              walk_start_q   <= 1'b1;
              walk_started_q <= 1'b1;
            end else if (wbyte == `CMD_SECTOR_ERASE) begin
              state_q   <= flash_seq_pkg::ST_WINDOW;
              sectors_q <= 8'h01 << aidx[6:4];
              win_cnt_q <= 11'(`WINDOW_CYC);
            end
          end
        end
        flash_seq_pkg::ST_PROG: begin
          // a weak cell stands for the internal program timer running out
          if (prog_cnt_q == 4'h1) begin
            state_q <= wear_fault_i ? flash_seq_pkg::ST_ERROR : flash_seq_pkg::ST_READ;
          end
          prog_cnt_q <= prog_cnt_q - 4'h1;
        end
        flash_seq_pkg::ST_BULK: begin
          if (walk_done) begin
            state_q   <= walk_fail ? flash_seq_pkg::ST_ERROR : flash_seq_pkg::ST_READ;
            sectors_q <= 8'h00;
          end
          // writes are not looked at here at all
        end
        flash_seq_pkg::ST_WINDOW: begin
          // any write restarts or ends the window; it runs out only in a cycle with no write pending, reads do not hold it
          if (wr_cmd && wbyte == `CMD_SECTOR_ERASE) begin
            sectors_q <= sectors_q | (8'h01 << aidx[6:4]);
            win_cnt_q <= 11'(`WINDOW_CYC);
          end else if (wr_cmd && wbyte == `CMD_ERASE_SUSPEND) begin
            state_q    <= flash_seq_pkg::ST_SUSP_PEND;
            susp_cnt_q <= 2'(`SUSPEND_CYC);
          end else if (wr_cmd) begin
            state_q   <= flash_seq_pkg::ST_READ;
            sectors_q <= 8'h00;
          end else if (win_cnt_q == 11'h001) begin
            state_q        <= flash_seq_pkg::ST_SECT;
            walk_start_q   <= 1'b1;
            walk_started_q <= 1'b1;
          end else begin
            win_cnt_q <= win_cnt_q - 11'h001;
          end
        end
        flash_seq_pkg::ST_SECT: begin
          // a walk ending in the same cycle as a command wins; the command is dropped
          if (walk_done) begin
            state_q   <= walk_fail ? flash_seq_pkg::ST_ERROR : flash_seq_pkg::ST_READ;
            sectors_q <= 8'h00;
          end else if (wr_cmd && wbyte == `CMD_RESET) begin
            state_q      <= flash_seq_pkg::ST_READ;
            sectors_q    <= 8'h00;
            walk_abort_q <= 1'b1;
          end else if (wr_cmd && wbyte == `CMD_ERASE_SUSPEND) begin
            state_q    <= flash_seq_pkg::ST_SUSP_PEND;
            susp_cnt_q <= 2'(`SUSPEND_CYC);
          end
        end
        flash_seq_pkg::ST_SUSP_PEND: begin
          // status keeps toggling for the minimum latency, then array read
          if (susp_cnt_q == 2'h1) state_q <= flash_seq_pkg::ST_SUSPENDED;
          susp_cnt_q <= susp_cnt_q - 2'h1;
        end
        flash_seq_pkg::ST_SUSPENDED: begin
          if (wr_cmd && wbyte == `CMD_ERASE_RESUME) begin
            state_q <= flash_seq_pkg::ST_SECT;
            if (!walk_started_q) begin
              walk_start_q   <= 1'b1;
              walk_started_q <= 1'b1;
            end
          end else if (wr_cmd && wbyte == `CMD_RESET) begin
            // the half-erased sector is simply left as the walker left it
            state_q      <= flash_seq_pkg::ST_READ;
            sectors_q    <= 8'h00;
            walk_abort_q <= 1'b1;
          end
          // program and other commands fall through unanswered
        end
        flash_seq_pkg::ST_ERROR: begin
          if (wr_cmd && wbyte == `CMD_RESET) begin
            state_q      <= flash_seq_pkg::ST_READ;
            sectors_q    <= 8'h00;
            walk_abort_q <= 1'b1;
          end
        end
        default: state_q <= flash_seq_pkg::ST_READ;
      endcase
      if (state_q == flash_seq_pkg::ST_READ) walk_started_q <= 1'b0;
      // busy comes from a flop, so it trails the state by one cycle
      busy_o <= (state_q != flash_seq_pkg::ST_READ) && (state_q != flash_seq_pkg::ST_SUSPENDED);
    end
  end

endmodule

// >>> verification/flash_seq_properties.sv
// port-level assertions for the flash sequencer, bound into its top module
`timescale 1ns/10ps
module flash_seq_checker (
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        busy_o
);
  logic       take;
  logic       rd_q;
  logic       arr_q;
  logic [2:0] since_wr_q;
  assign take = hsel_i & hready_i & htrans_i[1];
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rd_q  <= 1'b0;
      arr_q <= 1'b0;
    end else if (take) begin
      rd_q  <= !hwrite_i;
      arr_q <= !haddr_i[14];
    end
  end
  // age of the last write, saturating so a long idle never wraps
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      since_wr_q <= 3'h7;
    end else if (take && hwrite_i) begin
      since_wr_q <= 3'h0;
    end else if (since_wr_q != 3'h7) begin
      since_wr_q <= since_wr_q + 3'h1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  resp_okay_a: assert property (hresp_o == 1'b0)
    else $error("bus response not okay");
  wait_state_a: assert property (take |=> !hreadyout_o ##1 hreadyout_o)
    else $error("data phase not one wait state");
  no_stray_a: assert property ($fell(hreadyout_o) |-> $past(take))
    else $error("wait state without a transfer");
  rdata_hold_a: assert property (!($rose(hreadyout_o) && rd_q) |-> $stable(hrdata_o))
    else $error("read data changed outside a read answer");
  flash_upper_a: assert property ($rose(hreadyout_o) && rd_q && arr_q |-> hrdata_o[31:8] == 24'h0)
    else $error("flash read upper bits not zero");
  stat_upper_a: assert property ($rose(hreadyout_o) && rd_q && !arr_q |-> hrdata_o[31:16] == 16'h0)
    else $error("status word upper bits not zero");
  reset_vals_a: assert property ($fell(sys_rst_i) |-> hrdata_o == 32'h0 && !busy_o && hreadyout_o)
    else $error("outputs not at reset values");
  busy_cause_a: assert property ($rose(busy_o) |-> since_wr_q < 3'h4)
    else $error("busy rose without a recent write");
endmodule
bind flash_erase_status_sequencer flash_seq_checker u_chk (.mclk_i, .sys_rst_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .busy_o);

// >>> verification/mcu_bus_model.sv
// host microcontroller model: AHB-Lite single transfers and flash command helpers
`timescale 1ns/10ps
`include "flash_seq_defs.svh"
module mcu_bus_model (
  input  wire logic        mclk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [31:0]      hwdata_o
);
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0000_0000;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge mclk_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= 2'h2;
    hwrite_o <= w;
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'h0;
    hwdata_o <= {24'h00_0000, d};
    do @(posedge mclk_i); while (hready_i !== 1'b1);
    q = hrdata_i[7:0];
    // released write data must not look valid
    hwdata_o <= ~{24'h00_0000, d};
  endtask
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, {18'h0_0000, idx, 2'h0}, d, q);
  endtask
  task automatic rd(input logic [11:0] idx, output logic [7:0] q);
    xfer(1'b0, {18'h0_0000, idx, 2'h0}, 8'h00, q);
  endtask
  task automatic unlock(input logic [7:0] c);
    wr(`UNLOCK_ADDR_A, `CMD_UNLOCK_1);
    wr(`UNLOCK_ADDR_B, `CMD_UNLOCK_2);
    wr(`UNLOCK_ADDR_A, c);
  endtask
  task automatic erase_cmd(input logic [11:0] idx, input logic [7:0] c);
    unlock(`CMD_ERASE_SETUP);
    wr(`UNLOCK_ADDR_A, `CMD_UNLOCK_1);
    wr(`UNLOCK_ADDR_B, `CMD_UNLOCK_2);
    wr(idx, c); // six writes in all, the last one picks the sector
  endtask
  // toggle polling: stop on two equal reads, re-check once when error shows
  task automatic poll(input logic [11:0] idx, output logic ok);
    logic [7:0] a;
    logic [7:0] b;
    ok = 1'b0;
    for (int n = 0; n < 500; n++) begin
      rd(idx, a);
      rd(idx, b);
      if (a[`TOGGLE_BIT] == b[`TOGGLE_BIT]) begin
        ok = 1'b1;
        break;
      end
      if (b[`ERROR_BIT]) begin
        rd(idx, a);
        rd(idx, b);
        ok = (a[`TOGGLE_BIT] == b[`TOGGLE_BIT]);
        break;
      end
    end
  endtask
endmodule

// >>> verification/tb_top.sv
// self-checking bench for the flash erase and status sequencer
`timescale 1ns/10ps
`include "flash_seq_defs.svh"
module tb_top;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        wear_fault_i = 1'b0;
  logic        hsel;
  logic        hwrite;
  logic        hreadyout;
  logic        busy;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [7:0]  a;
  logic [7:0]  b;
  logic        ok;
  int          bad_count = 0;
  int          n_checks = 0;
  always #25 mclk_i = ~mclk_i;
  flash_erase_status_sequencer dut (.mclk_i, .sys_rst_i, .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .wear_fault_i, .hrdata_o(hrdata), .hreadyout_o(hreadyout),
    .hresp_o(), .busy_o(busy));
  mcu_bus_model mcu (.mclk_i, .hready_i(hreadyout), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic prog(input logic [11:0] idx, input logic [7:0] d, input logic exp_ok);
    mcu.unlock(`CMD_PROGRAM);
    mcu.wr(idx, d);
    mcu.poll(idx, ok);
    chk("program status", {7'h0, exp_ok}, {7'h0, ok});
    mcu.wr(12'h000, `CMD_RESET);
  endtask
  task automatic t_program;
    prog(12'h012, 8'h3C, 1'b1);
    mcu.rd(12'h012, a);
    chk("readback", 8'h3C, a);
    mcu.unlock(`CMD_PROGRAM);
    mcu.wr(12'h012, 8'h7C);
    mcu.rd(12'h012, a);
    chk("one over zero", 8'h01, {7'h0, a[`ERROR_BIT]});
    mcu.wr(12'h000, `CMD_RESET);
    wear_fault_i <= 1'b1;
    prog(12'h013, 8'h30, 1'b0);
    wear_fault_i <= 1'b0;
  endtask
  task automatic t_bulk(input logic fault);
    wear_fault_i <= fault;
    mcu.erase_cmd(`UNLOCK_ADDR_A, `CMD_BULK_ERASE);
    mcu.rd(12'h070, a);
    chk("bulk busy", 8'h01, {7'h0, busy});
    mcu.wr(`UNLOCK_ADDR_A, `CMD_RESET);
    mcu.rd(12'h070, b);
    chk("bulk toggle", 8'h01, {7'h0, a[`TOGGLE_BIT] ^ b[`TOGGLE_BIT]});
    chk("bulk window", 8'h01, {7'h0, b[`WINDOW_BIT]});
    mcu.poll(12'h070, ok);
    chk("bulk result", {7'h0, !fault}, {7'h0, ok});
    mcu.wr(12'h000, `CMD_RESET);
    wear_fault_i <= 1'b0;
  endtask
  task automatic t_sector;
    mcu.rd(12'h012, a);
    chk("bulk erased", `ERASED_BYTE, a);
    prog(12'h025, 8'h11, 1'b1);
    prog(12'h055, 8'h22, 1'b1);
    prog(12'h070, 8'h33, 1'b1);
    mcu.erase_cmd(12'h020, `CMD_SECTOR_ERASE);
    mcu.rd(12'h025, a);
    chk("window open", 8'h00, {7'h0, a[`WINDOW_BIT]});
    mcu.wr(12'h050, `CMD_SECTOR_ERASE);
    mcu.wr(12'h000, `CMD_ERASE_SUSPEND);
    mcu.rd(12'h025, a);
    mcu.rd(12'h025, b);
    chk("toggle stopped", `SUSPENDED_JUNK, a);
    chk("suspended junk", `SUSPENDED_JUNK, b);
    mcu.rd(12'h070, a);
    chk("other sector", 8'h33, a);
    mcu.unlock(`CMD_PROGRAM);
    mcu.wr(12'h071, 8'h44);
    mcu.rd(12'h071, a);
    chk("no program", `ERASED_BYTE, a);
    mcu.wr(12'h000, `CMD_ERASE_RESUME);
    mcu.rd(12'h055, a);
    mcu.wr(`UNLOCK_ADDR_A, `CMD_UNLOCK_1);
    mcu.rd(12'h055, b);
    chk("resumed toggle", 8'h01, {7'h0, a[`TOGGLE_BIT] ^ b[`TOGGLE_BIT]});
    chk("erasing window", 8'h01, {7'h0, b[`WINDOW_BIT]});
    mcu.poll(12'h025, ok);
    chk("sector done", 8'h01, {7'h0, ok});
    mcu.rd(12'h055, a);
    chk("added sector", `ERASED_BYTE, a);
  endtask
  task automatic t_abort;
    mcu.erase_cmd(12'h060, `CMD_SECTOR_ERASE);
    mcu.wr(`UNLOCK_ADDR_A, `CMD_UNLOCK_1);
    mcu.wr(12'h000, `CMD_RESET);
    mcu.rd(12'h060, a);
    chk("window abort", `ERASED_BYTE, a);
    mcu.unlock(`CMD_ERASE_SETUP);
    mcu.unlock(8'h56);
    mcu.wr(`UNLOCK_ADDR_A, `CMD_BULK_ERASE);
    mcu.rd(12'h070, a);
    chk("bad sequence", 8'h33, a);
    mcu.wr(12'h000, `CMD_RESET);
    mcu.erase_cmd(12'h070, `CMD_SECTOR_ERASE);
    repeat (2100) @(posedge mclk_i);
    mcu.rd(12'h070, a);
    chk("window expired", 8'h01, {7'h0, a[`WINDOW_BIT]});
    mcu.wr(12'h000, `CMD_ERASE_SUSPEND);
    mcu.rd(12'h070, a);
    chk("sector suspend", `SUSPENDED_JUNK, a);
    mcu.wr(12'h000, `CMD_RESET);
    mcu.poll(12'h070, ok);
    mcu.xfer(1'b0, `STATUS_REG_OFFSET, 8'h00, a);
    chk("idle state", 8'h00, {3'h0, a[4:0]});
  endtask
  initial begin
    repeat (20) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    t_program;
    t_bulk(1'b1);
    t_bulk(1'b0);
    t_sector;
    t_abort;
    report_and_stop;
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    bad_count++;
    report_and_stop;
  end
endmodule
